// *** rtcf_regs.sv ***
// RTC time and calendar field registers behind an APB slave, with a
// one-second counting chain for the live bank.
// Assumes tick is a one-cycle pulse synchronous to pclk, once per second.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "rtcf_map.svh"
module rtcf_regs #(
   parameter int ADDR_W = 12
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [ADDR_W-1:0]  paddr,
   input  wire rtcf_pkg::rtcf_data_t pwdata,
   output rtcf_pkg::rtcf_data_t    prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               tick,
   output logic                    hour_format_select
);
   import rtcf_pkg::*;

   // The in-range test needs at least one address bit above the index
   if (ADDR_W < 7) begin : g_addr_w_check
      $error("rtcf_regs: ADDR_W must be at least 7");
   end

   rtcf_idx_t    idx;
   logic         in_range;
   logic         wr_acc;
   logic         rd_setup;
   rtcf_bank_e   page_reg;
   logic         fmt_reg;
   rtcf_data_t   prdata_reg;
   rtcf_data_t   rd_next;

   // Live bank
   logic [`RTCF_SEC_W-1:0]  tick_digits;
   logic [`RTCF_MIN_W-1:0]  second_tier_digits;
   logic [`RTCF_HOUR_W-1:0] day_part_digits;
   logic [`RTCF_WDAY_W-1:0] wday_reg;
   logic [`RTCF_DATE_W-1:0] month_position;
   // Alarm bank
   logic [`RTCF_MIN_W-1:0]  alm_min_reg;
   logic [`RTCF_HOUR_W-1:0] alm_hour_reg;
   logic [`RTCF_WDAY_W-1:0] alm_wday_reg;
   logic [`RTCF_DATE_W-1:0] alm_date_reg;

   // Step inputs: 0 sec, 1 min, 2 hour 24h, 3 date, 4 hour digits 12h
   rtcf_bcd_t step_cur [5];
   rtcf_bcd_t step_nxt [5];
   logic      step_wrap [5];
   rtcf_bcd_t step_lo  [5];
   rtcf_bcd_t step_hi  [5];

   assign step_cur[0] = tick_digits;
   assign step_cur[1] = second_tier_digits;
   assign step_cur[2] = {1'b0, day_part_digits};
   assign step_cur[3] = {1'b0, month_position};
   assign step_cur[4] = {2'b00, day_part_digits[4:0]};
   assign step_lo[0]  = `RTCF_ZERO;
   assign step_lo[1]  = `RTCF_ZERO;
   assign step_lo[2]  = `RTCF_ZERO;
   assign step_lo[3]  = `RTCF_DATE_MIN;
   assign step_lo[4]  = `RTCF_ZERO;
   assign step_hi[0]  = `RTCF_SEC_MAX;
   assign step_hi[1]  = `RTCF_MIN_MAX;
   assign step_hi[2]  = `RTCF_H24_MAX;
   assign step_hi[3]  = `RTCF_DATE_MAX;
   assign step_hi[4]  = `RTCF_H12_MAX;

   for (genvar g = 0; g < 5; g++) begin : g_step
      rtcf_bcd_step u_step (
         .cur  (step_cur[g]),
         .lo   (step_lo[g]),
         .hi   (step_hi[g]),
         .nxt  (step_nxt[g]),
         .wrap (step_wrap[g])
      );
   end

   logic min_carry;
   logic hour_carry;
   logic day_carry;
   logic hour_wrap;
   logic [`RTCF_HOUR_W-1:0] hour_next;

   assign min_carry  = tick && step_wrap[0];
   assign hour_carry = min_carry && step_wrap[1];

   always_comb begin
      if (fmt_reg) begin
         hour_next = step_nxt[2][5:0];
         hour_wrap = step_wrap[2];
      end else begin
         // AM 11 goes to PM 0; PM 11 goes to AM 0 and ends the day
         hour_next = {day_part_digits[`RTCF_PM_BIT] ^ step_wrap[4],
                      step_nxt[4][4:0]};
         hour_wrap = step_wrap[4] && day_part_digits[`RTCF_PM_BIT];
      end
   end

   assign day_carry = hour_carry && hour_wrap;

   // APB decode; every transfer completes with no wait state
   assign idx      = paddr[5:2];
   assign in_range = (paddr[ADDR_W-1:6] == '0) && (paddr[1:0] == 2'b00);
   assign wr_acc   = psel && penable && pwrite && in_range
                     && (idx != `RTCF_IDX_RSVD);
   assign rd_setup = psel && !penable && !pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable
                     && (!in_range || idx == `RTCF_IDX_RSVD);
   assign prdata   = prdata_reg;
   assign hour_format_select = fmt_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_reg <= RTCF_BANK_TIME;
      end else if (wr_acc && idx == `RTCF_IDX_PAGE) begin
         page_reg <= rtcf_bank_e'(pwdata[`RTCF_PAGE_BIT]);
      end
   end

   // Format bit sits on the alarm page; no reset, like the fields
   always_ff @(posedge pclk) begin
      if (wr_acc && idx == `RTCF_IDX_FMT
          && page_reg == RTCF_BANK_ALARM) begin
         fmt_reg <= pwdata[`RTCF_FMT_BIT];
      end
   end

   // Live bank: counting chain, a software write wins for its field
   always_ff @(posedge pclk) begin
      if (tick) begin
         tick_digits <= step_nxt[0];
      end
      if (min_carry) begin
         second_tier_digits <= step_nxt[1];
      end
      if (hour_carry) begin
         day_part_digits <= hour_next;
      end
      if (day_carry) begin
         wday_reg <= (wday_reg == `RTCF_WDAY_MAX) ? 3'h0
                     : 3'(wday_reg + 3'h1);
         month_position <= step_nxt[3][5:0];
      end
      if (wr_acc && page_reg == RTCF_BANK_TIME) begin
         case (idx)
            `RTCF_IDX_SEC:  tick_digits <= pwdata[6:0];
            `RTCF_IDX_MIN:  second_tier_digits <= pwdata[6:0];
            `RTCF_IDX_HOUR: day_part_digits <= pwdata[5:0];
            `RTCF_IDX_WDAY: wday_reg <= pwdata[2:0];
            `RTCF_IDX_DATE: month_position <= pwdata[5:0];
            default: ;
         endcase
      end
   end

   // Alarm bank
   always_ff @(posedge pclk) begin
      if (wr_acc && page_reg == RTCF_BANK_ALARM) begin
         case (idx)
            `RTCF_IDX_MIN:  alm_min_reg <= pwdata[6:0];
            `RTCF_IDX_HOUR: alm_hour_reg <= pwdata[5:0];
            `RTCF_IDX_WDAY: alm_wday_reg <= pwdata[2:0];
            `RTCF_IDX_DATE: alm_date_reg <= pwdata[5:0];
            default: ;
         endcase
      end
   end

   // Read mux; upper bits of every field read as zero
   always_comb begin
      rd_next = '0;
      if (in_range) begin
         case (idx)
            `RTCF_IDX_SEC:
               if (page_reg == RTCF_BANK_TIME) begin
                  rd_next[6:0] = tick_digits;
               end
            `RTCF_IDX_MIN:
               rd_next[6:0] = (page_reg == RTCF_BANK_TIME)
                              ? second_tier_digits : alm_min_reg;
            `RTCF_IDX_HOUR:
               rd_next[5:0] = (page_reg == RTCF_BANK_TIME)
                              ? day_part_digits : alm_hour_reg;
            `RTCF_IDX_WDAY:
               rd_next[2:0] = (page_reg == RTCF_BANK_TIME)
                              ? wday_reg : alm_wday_reg;
            `RTCF_IDX_DATE:
               rd_next[5:0] = (page_reg == RTCF_BANK_TIME)
                              ? month_position : alm_date_reg;
            `RTCF_IDX_FMT:
               if (page_reg == RTCF_BANK_ALARM) begin
                  rd_next[`RTCF_FMT_BIT] = fmt_reg;
               end
            `RTCF_IDX_PAGE:
               rd_next[`RTCF_PAGE_BIT] = page_reg;
            default: rd_next = '0;
         endcase
      end
   end

   // Captured in the setup cycle so the access phase shows a stable word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
      end else if (rd_setup) begin
         prdata_reg <= rd_next;
      end
   end

   property p_sec_top;
      @(posedge pclk) disable iff (!presetn)
      (rd_setup && in_range && idx == `RTCF_IDX_SEC)
      |=> (prdata[31:7] == '0)
          && (prdata[6:0] == ($past(page_reg == RTCF_BANK_TIME)
                              ? $past(tick_digits) : `RTCF_ZERO));
   endproperty
   a_sec_top: assert property (p_sec_top)
      else $error("seconds read shows bits above six");

   property p_alarm_min_write;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && idx == `RTCF_IDX_MIN && page_reg == RTCF_BANK_ALARM
       && !min_carry)
      |=> (second_tier_digits == $past(second_tier_digits))
          && (alm_min_reg == $past(pwdata[6:0]));
   endproperty
   a_alarm_min_write: assert property (p_alarm_min_write)
      else $error("alarm minute write misrouted");

   property p_h24_wrap;
      @(posedge pclk) disable iff (!presetn)
      (hour_carry && fmt_reg && day_part_digits == 6'h23 && !wr_acc)
      |=> (day_part_digits == 6'h00);
   endproperty
   a_h24_wrap: assert property (p_h24_wrap)
      else $error("24-hour wrap wrong");

   property p_h12_pm;
      @(posedge pclk) disable iff (!presetn)
      (hour_carry && !fmt_reg && day_part_digits == 6'h11 && !wr_acc)
      |=> (day_part_digits == 6'h20) && $stable(wday_reg);
   endproperty
   a_h12_pm: assert property (p_h12_pm)
      else $error("12-hour AM to PM step wrong");

   property p_wday_wrap;
      @(posedge pclk) disable iff (!presetn)
      (day_carry && wday_reg == 3'h6 && !wr_acc) |=> (wday_reg == 3'h0);
   endproperty
   a_wday_wrap: assert property (p_wday_wrap)
      else $error("weekday does not wrap to Sunday");

   property p_date_wrap;
      @(posedge pclk) disable iff (!presetn)
      (day_carry && month_position == 6'h31 && !wr_acc)
      |=> (month_position == 6'h01);
   endproperty
   a_date_wrap: assert property (p_date_wrap)
      else $error("day of month does not wrap to one");

   property p_page_read;
      @(posedge pclk) disable iff (!presetn)
      (rd_setup && in_range && idx == `RTCF_IDX_HOUR
       && page_reg == RTCF_BANK_ALARM)
      |=> (prdata[5:0] == $past(alm_hour_reg)) && (prdata[31:6] == '0);
   endproperty
   a_page_read: assert property (p_page_read)
      else $error("alarm page read shows wrong bank");

   property p_reset_page;
      @(posedge pclk)
      $rose(presetn) |-> (page_reg == RTCF_BANK_TIME) && (prdata == '0);
   endproperty
   a_reset_page: assert property (p_reset_page)
      else $error("page or read data not cleared by reset");
endmodule

// *** rtcf_map.svh ***
// Register indices, field layouts and field limits of the RTC time fields.
// Assumes byte-wide registers placed one per 32-bit APB word.
`ifndef RTCF_MAP_SVH
`define RTCF_MAP_SVH

// Register indices; the byte address is four times the index
`define RTCF_IDX_SEC     4'h0
`define RTCF_IDX_MIN     4'h1
`define RTCF_IDX_HOUR    4'h2
`define RTCF_IDX_WDAY    4'h4
`define RTCF_IDX_DATE    4'h5
`define RTCF_IDX_FMT     4'h6
`define RTCF_IDX_PAGE    4'h8
`define RTCF_IDX_RSVD    4'hd

// Field widths
`define RTCF_SEC_W       7
`define RTCF_MIN_W       7
`define RTCF_HOUR_W      6
`define RTCF_WDAY_W      3
`define RTCF_DATE_W      6

// Field positions
`define RTCF_PM_BIT      5
`define RTCF_PAGE_BIT    0
`define RTCF_FMT_BIT     0

// Packed-BCD limits, held seven bits wide; the weekday top is three bits
`define RTCF_SEC_MAX     7'h59
`define RTCF_MIN_MAX     7'h59
`define RTCF_H24_MAX     7'h23
`define RTCF_H12_MAX     7'h11
`define RTCF_DATE_MAX    7'h31
`define RTCF_DATE_MIN    7'h01
`define RTCF_ZERO        7'h00
`define RTCF_WDAY_MAX    3'h6

// Reset value of the page select
`define RTCF_PAGE_RST    1'b0

`endif

// *** rtcf_pkg.sv ***
// Types shared by the RTC time-field register block.
// Assumes rtcf_map.svh carries the numeric constants.
package rtcf_pkg;
   typedef logic [31:0] rtcf_data_t;
   typedef logic [3:0]  rtcf_idx_t;
   typedef logic [6:0]  rtcf_bcd_t;
   typedef enum logic {RTCF_BANK_TIME, RTCF_BANK_ALARM} rtcf_bank_e;
endpackage

// *** rtcf_bcd_step.sv ***
// One packed-BCD counting step with wrap from a top value to a low value.
// Assumes the current value is valid BCD within the given limits.
`timescale 1ns/1ns
module rtcf_bcd_step
   import rtcf_pkg::*;
(
   input  wire rtcf_pkg::rtcf_bcd_t cur,
   input  wire rtcf_pkg::rtcf_bcd_t lo,
   input  wire rtcf_pkg::rtcf_bcd_t hi,
   output rtcf_pkg::rtcf_bcd_t      nxt,
   output logic                     wrap
);
   always_comb begin
      wrap = (cur == hi);
      if (wrap) begin
         nxt = lo;
      end else if (cur[3:0] == 4'h9) begin
         nxt = {3'(cur[6:4] + 3'h1), 4'h0};
      end else begin
         nxt = 7'(cur + 7'h01);
      end
   end
endmodule

// *** tb_top.sv ***
// Self-checking testbench for the RTC time-field register block.
// Assumes rtcf_regs answers APB with no wait states and a 20 MHz pclk.
`timescale 1ns/1ns
`include "rtcf_map.svh"
module tb_top;
   import rtcf_pkg::*;
   logic       pclk;
   logic       presetn;
   logic       psel;
   logic       penable;
   logic       pwrite;
   logic       tick;
   logic [11:0] paddr;
   rtcf_data_t pwdata;
   rtcf_data_t prdata;
   logic       pready;
   logic       pslverr;
   logic       hour_format_select;
   rtcf_data_t rdv;
   logic       errv;
   int         miscompares;
   int         num_checks;

   rtcf_regs #(.ADDR_W(12)) i_rtcf_regs (
      .pclk               (pclk),
      .presetn            (presetn),
      .psel               (psel),
      .penable            (penable),
      .pwrite             (pwrite),
      .paddr              (paddr),
      .pwdata             (pwdata),
      .prdata             (prdata),
      .pready             (pready),
      .pslverr            (pslverr),
      .tick               (tick),
      .hour_format_select (hour_format_select)
   );

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic chk(input rtcf_data_t act, input rtcf_data_t exp);
      num_checks++;
      if (act !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
      end
   endtask

   // One APB transfer; read data and error land in rdv and errv
   task automatic apb(input logic wr, input logic [11:0] a,
                      input rtcf_data_t d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a wait for the answer
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input rtcf_idx_t idx, input rtcf_data_t d);
      apb(1'b1, {6'h00, idx, 2'b00}, d);
   endtask

   task automatic rd(input rtcf_idx_t idx, input rtcf_data_t exp);
      apb(1'b0, {6'h00, idx, 2'b00}, 32'h0);
      chk(rdv, exp);
      chk({31'h0, errv}, 32'h0);
   endtask

   // Reads a live field twice and accepts it only when both reads agree
   task automatic rd_twice(input rtcf_idx_t idx, input rtcf_data_t exp);
      rtcf_data_t first;
      apb(1'b0, {6'h00, idx, 2'b00}, 32'h0);
      first = rdv;
      apb(1'b0, {6'h00, idx, 2'b00}, 32'h0);
      chk(rdv, first);
      chk(rdv, exp);
   endtask

   task automatic do_tick;
      @(posedge pclk);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
   endtask

   task automatic t_fields;
      rd(`RTCF_IDX_PAGE, 32'h0);
      wr(`RTCF_IDX_PAGE, 32'h1);
      wr(`RTCF_IDX_FMT, 32'h1);
      rd(`RTCF_IDX_FMT, 32'h1);
      wr(`RTCF_IDX_PAGE, 32'h0);
      chk({31'h0, hour_format_select}, 32'h1);
      wr(`RTCF_IDX_SEC, 32'h59);
      wr(`RTCF_IDX_MIN, 32'h59);
      wr(`RTCF_IDX_HOUR, 32'h23);
      wr(`RTCF_IDX_WDAY, 32'h6);
      wr(`RTCF_IDX_DATE, 32'h31);
      rd(`RTCF_IDX_SEC, 32'h59);
      rd(`RTCF_IDX_MIN, 32'h59);
      rd(`RTCF_IDX_HOUR, 32'h23);
      rd(`RTCF_IDX_WDAY, 32'h6);
      rd(`RTCF_IDX_DATE, 32'h31);
   endtask

   // Full carry chain from 23:59:59 Saturday the 31st
   task automatic t_carry;
      do_tick();
      rd(`RTCF_IDX_SEC, 32'h00);
      rd(`RTCF_IDX_MIN, 32'h00);
      rd(`RTCF_IDX_HOUR, 32'h00);
      rd(`RTCF_IDX_WDAY, 32'h0);
      rd(`RTCF_IDX_DATE, 32'h01);
      rd_twice(`RTCF_IDX_SEC, 32'h00);
   endtask

   task automatic t_12h;
      wr(`RTCF_IDX_PAGE, 32'h1);
      wr(`RTCF_IDX_FMT, 32'h0);
      wr(`RTCF_IDX_PAGE, 32'h0);
      chk({31'h0, hour_format_select}, 32'h0);
      wr(`RTCF_IDX_HOUR, 32'h11);
      wr(`RTCF_IDX_MIN, 32'h59);
      wr(`RTCF_IDX_SEC, 32'h59);
      do_tick();
      rd(`RTCF_IDX_HOUR, 32'h20);
      wr(`RTCF_IDX_HOUR, 32'h31);
      wr(`RTCF_IDX_MIN, 32'h59);
      wr(`RTCF_IDX_SEC, 32'h59);
      wr(`RTCF_IDX_DATE, 32'h15);
      do_tick();
      rd(`RTCF_IDX_HOUR, 32'h00);
      rd(`RTCF_IDX_DATE, 32'h16);
      rd(`RTCF_IDX_WDAY, 32'h1);
   endtask

   task automatic t_bank;
      wr(`RTCF_IDX_PAGE, 32'h1);
      rd(`RTCF_IDX_PAGE, 32'h1);
      wr(`RTCF_IDX_MIN, 32'h42);
      wr(`RTCF_IDX_SEC, 32'h33);
      wr(`RTCF_IDX_HOUR, 32'h27);
      rd(`RTCF_IDX_HOUR, 32'h27);
      rd(`RTCF_IDX_MIN, 32'h42);
      rd(`RTCF_IDX_SEC, 32'h00);
      wr(`RTCF_IDX_PAGE, 32'h0);
      rd(`RTCF_IDX_MIN, 32'h00);
      rd(`RTCF_IDX_SEC, 32'h00);
      rd(`RTCF_IDX_HOUR, 32'h00);
   endtask

   // Reserved index, unused index, misaligned and out-of-range addresses
   task automatic t_bad;
      apb(1'b0, {6'h00, `RTCF_IDX_RSVD, 2'b00}, 32'h0);
      chk({31'h0, errv}, 32'h1);
      chk(rdv, 32'h0);
      wr(4'h3, 32'h12);
      rd(4'h3, 32'h0);
      apb(1'b0, 12'h001, 32'h0);
      chk({31'h0, errv}, 32'h1);
      apb(1'b1, 12'h044, 32'h22);
      chk({31'h0, errv}, 32'h1);
      rd(`RTCF_IDX_MIN, 32'h00);
   endtask

   task automatic test_done;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge pclk);
      miscompares++;
      test_done();
   end

   initial begin
      miscompares = 0;
      num_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      tick = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_fields();
      t_carry();
      t_12h();
      t_bank();
      t_bad();
      test_done();
   end
endmodule
